/* rtl/bus_cycle_ctrl.sv */
// bus cycle definition outputs, clock doubling control and suspend handshake
//
// Behaviour
// - definitions valid with the cycle strobe
// - locked level late on pipelined cycles
// - definitions float during hold or float outside suspend
// - memory data cycles, locked variants low
// - halt and shutdown special byte enables
// - config bit six enables frequency doubling
// - power up undoubled until bit set
// - doubled only after lock wait elapses
// - clearing bit leaves doubled mode immediately
// - suspend keeps pll running, clock steady
// - drain work, wait coprocessor idle, acknowledge
// - suspend stops core clocks
// - negated request resumes where it stopped
// - sleep request ignored until enable bit
// - acknowledge floats until enable bit set
// - halt also enters suspend
// - halt suspend watches three interrupts
// - monitored interrupt wakes from halt suspend
// - fixed pin levels while suspended
// - request suspend latches interrupts, refuses hold and cycles
// - doubled mode may persist while suspended
module bus_cycle_ctrl (
   input  wire logic                                    clk,
   input  wire logic                                    rst_b,
   // core side bus cycle request
   input  wire logic                                    cyc_start,
   input  wire bus_cycle_pkg::cyc_kind_t                cyc_kind,
   input  wire logic                                    cyc_locked,
   input  wire logic                                    cyc_pipelined,
   input  wire logic                                    cyc_smm,
   input  wire logic [bus_cycle_pkg::ADDR_W-1:0]        cyc_addr,
   input  wire logic [3:0]                              cyc_be_n,
   output logic                                         cyc_ready,
   // core side status
   input  wire logic                                    halt_exec,
   input  wire logic                                    core_idle,
   input  wire logic                                    maskable_irq_unmasked,
   input  wire logic [2:0]                              irq_taken,
   input  wire logic                                    hold_grant,
   input  wire logic                                    float_req,
   output logic                                         core_clock_run,
   output logic      [2:0]                              wake_source,
   output logic      [2:0]                              irq_latched,
   // configuration port access
   input  wire logic                                    io_wr,
   input  wire logic                                    io_rd,
   input  wire logic [15:0]                             io_addr,
   input  wire logic [7:0]                              io_wdata,
   output logic      [7:0]                              io_rdata,
   output logic                                         io_rvalid,
   // pll
   input  wire logic                                    pll_lock,
   output logic                                         pll_enable,
   output logic                                         clock_doubled,
   // pins
   input  wire logic                                    sleep_request_n,
   input  wire logic                                    coproc_busy_n,
   input  wire logic                                    nmi,
   input  wire logic                                    sysmgmt_irq_n,
   input  wire logic                                    maskable_irq,
   output logic                                         cycle_start_strobe_n,
   output logic                                         sysmgmt_strobe_n,
   output logic                                         mem_io_n,
   output logic                                         data_ctrl_n,
   output logic                                         write_read_n,
   output logic                                         atomic_n,
   output logic      [bus_cycle_pkg::ADDR_W-1:0]        addr_upper,
   output logic      [3:0]                              byte_lane_enables_n,
   output logic                                         bus_def_oe,
   output logic                                         data_bus_float,
   output logic                                         bus_release_ack,
   output logic                                         sleep_ack_n,
   output logic                                         sleep_ack_oe
);
   localparam int LCW = bus_cycle_pkg::LOCK_CNT_W;
   localparam int AW  = bus_cycle_pkg::ADDR_W;

   if (bus_cycle_pkg::LOCK_CYCLES >= (1 << LCW) || bus_cycle_pkg::LOCK_CYCLES < 1)
   begin : g_bad_lock
      $error("lock wait does not fit its counter");
   end

   typedef struct packed {
      bus_cycle_pkg::sleep_request_n_state_t st;
      logic [7:0]                 cfg;
      logic                       idx_ok;
      logic [LCW-1:0]             lock_cnt;
      logic                       doubled;
      logic                       strobe_n;
      logic                       smm_strobe_n;
      logic                       mio_n;
      logic                       dc_n;
      logic                       wr_n;
      logic                       atomic_n;
      logic                       atomic_pend;
      logic                       atomic_next;
      logic [AW-1:0]              addr;
      logic [3:0]                 be_n;
      logic                       def_oe;
      logic                       release_ack;
      logic                       data_float;
      logic [2:0]                 irq_latched;
      logic [2:0]                 wake;
      logic [7:0]                 rdata;
      logic                       rvalid;
   } state_t;

   state_t s;
   state_t next_s;

   logic [bus_cycle_pkg::PIN_W-1:0] pins_s;
   logic                            enc_mio_n;
   logic                            enc_dc_n;
   logic                            enc_wr_n;
   logic                            enc_atomic_n;
   logic                            enc_special;
   logic [3:0]                      enc_be_n;
   logic                            sleep_en;
   logic                            suspended;
   logic [2:0]                      irq_now;
   logic [2:0]                      wake_now;

   // every asynchronous pin is resynchronised before use
   pin_sync #(
      .W       (bus_cycle_pkg::PIN_W),
      .RST_VAL (bus_cycle_pkg::PIN_IDLE)
   ) u_pin_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .din   ({pll_lock, maskable_irq, sysmgmt_irq_n, nmi, coproc_busy_n, sleep_request_n}),
      .dout  (pins_s)
   );

   cycle_def_encode u_encode (
      .kind         (cyc_kind),
      .locked       (cyc_locked),
      .mio_n        (enc_mio_n),
      .dc_n         (enc_dc_n),
      .wr_n         (enc_wr_n),
      .atomic_n     (enc_atomic_n),
      .special      (enc_special),
      .special_be_n (enc_be_n)
   );

   assign sleep_en  = s.cfg[bus_cycle_pkg::SLEEP_EN_POS];
   assign suspended = (s.st == bus_cycle_pkg::ST_SLEEP_REQ) ||
                      (s.st == bus_cycle_pkg::ST_SLEEP_HALT);

   always_comb begin
      irq_now = '0;
      irq_now[bus_cycle_pkg::IRQ_NMI]  = pins_s[bus_cycle_pkg::PIN_NMI];
      irq_now[bus_cycle_pkg::IRQ_SYSMGMT]  = !pins_s[bus_cycle_pkg::PIN_SYSMGMT_N];
      irq_now[bus_cycle_pkg::IRQ_MASKABLE] = pins_s[bus_cycle_pkg::PIN_MASKABLE];
      wake_now = irq_now;
      wake_now[bus_cycle_pkg::IRQ_MASKABLE] = irq_now[bus_cycle_pkg::IRQ_MASKABLE] &&
                                              maskable_irq_unmasked;
   end

   // cycles are still accepted while draining so pending bus work can finish
   assign cyc_ready = !suspended;

   always_comb begin
      next_s        = s;
      next_s.strobe_n     = 1'b1;
      next_s.smm_strobe_n = 1'b1;
      next_s.rvalid = 1'b0;
      next_s.wake   = '0;

      // index write arms a single data access, so each access needs a fresh index
      if (io_wr && io_addr == bus_cycle_pkg::INDEX_PORT) begin
         next_s.idx_ok = (io_wdata == bus_cycle_pkg::CONFIG_INDEX);
      end else if ((io_wr || io_rd) && io_addr == bus_cycle_pkg::DATA_PORT) begin
         next_s.idx_ok = 1'b0;
         if (io_wr && s.idx_ok) begin
            next_s.cfg = io_wdata;
         end
      end
      if (io_rd && (io_addr == bus_cycle_pkg::INDEX_PORT ||
                    io_addr == bus_cycle_pkg::DATA_PORT)) begin
         next_s.rvalid = 1'b1;
         next_s.rdata  = (io_addr == bus_cycle_pkg::DATA_PORT && s.idx_ok) ?
                         s.cfg : bus_cycle_pkg::UNMAPPED_READ;
      end

      // doubling waits out the lock time; clearing the bit drops it at once
      if (!next_s.cfg[bus_cycle_pkg::FREQ_DOUBLE_POS]) begin
         next_s.lock_cnt = '0;
         next_s.doubled  = 1'b0;
      end else begin
         if (s.lock_cnt != bus_cycle_pkg::LOCK_CNT_MAX) begin
            next_s.lock_cnt = s.lock_cnt + 1'b1;
         end
         // losing lock, e.g. after an input clock change, falls back to undoubled
         next_s.doubled = (s.lock_cnt == bus_cycle_pkg::LOCK_CNT_MAX) &&
                          pins_s[bus_cycle_pkg::PIN_LOCK];
      end

      // set wins over clear
      next_s.irq_latched = s.irq_latched & ~irq_taken;
      if (s.st == bus_cycle_pkg::ST_SLEEP_REQ) begin
         next_s.irq_latched = next_s.irq_latched | irq_now;
      end

      case (s.st)
         bus_cycle_pkg::ST_RUN: begin
            if (sleep_en && !pins_s[bus_cycle_pkg::PIN_SLEEP_N]) begin
               next_s.st = bus_cycle_pkg::ST_DRAIN_REQ;
            end else if (sleep_en && halt_exec) begin
               next_s.st = bus_cycle_pkg::ST_DRAIN_HALT;
            end
         end
         bus_cycle_pkg::ST_DRAIN_REQ: begin
            if (core_idle && pins_s[bus_cycle_pkg::PIN_BUSY_N]) begin
               next_s.st = bus_cycle_pkg::ST_SLEEP_REQ;
            end
         end
         bus_cycle_pkg::ST_DRAIN_HALT: begin
            if (core_idle && pins_s[bus_cycle_pkg::PIN_BUSY_N]) begin
               next_s.st = bus_cycle_pkg::ST_SLEEP_HALT;
            end
         end
         bus_cycle_pkg::ST_SLEEP_REQ: begin
            if (pins_s[bus_cycle_pkg::PIN_SLEEP_N]) begin
               next_s.st = bus_cycle_pkg::ST_RUN;
            end
         end
         bus_cycle_pkg::ST_SLEEP_HALT: begin
            // sleep request is not looked at here
            if (|wake_now) begin
               next_s.st   = bus_cycle_pkg::ST_RUN;
               next_s.wake = wake_now;
            end
         end
         default: begin
            next_s.st = bus_cycle_pkg::ST_RUN;
         end
      endcase

      // a pipelined cycle shows its locked level one clock after its strobe
      if (s.atomic_pend) begin
         next_s.atomic_n = s.atomic_next;
      end
      next_s.atomic_pend = 1'b0;
      if (cyc_start && cyc_ready) begin
         next_s.strobe_n     = cyc_smm;
         next_s.smm_strobe_n = !cyc_smm;
         next_s.mio_n = enc_mio_n;
         next_s.dc_n  = enc_dc_n;
         next_s.wr_n  = enc_wr_n;
         next_s.addr  = enc_special ? '0 : cyc_addr;
         next_s.be_n  = enc_special ? enc_be_n : cyc_be_n;
         if (cyc_pipelined) begin
            next_s.atomic_pend = 1'b1;
            next_s.atomic_next = enc_atomic_n;
         end else begin
            next_s.atomic_n = enc_atomic_n;
         end
      end

      next_s.release_ack = hold_grant && !suspended;
      next_s.def_oe      = !(next_s.release_ack || float_req);
      next_s.data_float  = !next_s.def_oe;

      if (next_s.st == bus_cycle_pkg::ST_SLEEP_REQ ||
          next_s.st == bus_cycle_pkg::ST_SLEEP_HALT) begin
         next_s.strobe_n     = 1'b1;
         next_s.smm_strobe_n = 1'b1;
         next_s.dc_n         = 1'b1;
         next_s.atomic_n     = 1'b1;
         next_s.atomic_pend  = 1'b0;
         next_s.addr         = '1;
         next_s.be_n         = '0;
         next_s.mio_n        = 1'b0;
         next_s.wr_n         = 1'b0;
         next_s.release_ack  = 1'b0;
         next_s.def_oe       = 1'b1;
         next_s.data_float   = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{st: bus_cycle_pkg::ST_RUN, cfg: bus_cycle_pkg::CONFIG_RESET,
                strobe_n: 1'b1, smm_strobe_n: 1'b1, dc_n: 1'b1, atomic_n: 1'b1,
                addr: '1, def_oe: 1'b1, data_float: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign cycle_start_strobe_n = s.strobe_n;
   assign sysmgmt_strobe_n     = s.smm_strobe_n;
   assign mem_io_n             = s.mio_n;
   assign data_ctrl_n          = s.dc_n;
   assign write_read_n         = s.wr_n;
   assign atomic_n             = s.atomic_n;
   assign addr_upper           = s.addr;
   assign byte_lane_enables_n  = s.be_n;
   assign bus_def_oe           = s.def_oe;
   assign data_bus_float       = s.data_float;
   assign bus_release_ack      = s.release_ack;
   assign sleep_ack_n          = !suspended;
   assign sleep_ack_oe         = sleep_en;
   // the pll is not gated by suspend so lock survives a steady input clock
   assign pll_enable           = s.cfg[bus_cycle_pkg::FREQ_DOUBLE_POS];
   assign clock_doubled        = s.doubled;
   assign core_clock_run       = !suspended;
   assign wake_source          = s.wake;
   assign irq_latched          = s.irq_latched;
   assign io_rdata             = s.rdata;
   assign io_rvalid            = s.rvalid;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_DEF_WITH_STROBE: assert property (
      cyc_start && cyc_ready |=> suspended || !(cycle_start_strobe_n && sysmgmt_strobe_n) &&
         mem_io_n == $past(enc_mio_n) && write_read_n == $past(enc_wr_n) &&
         data_ctrl_n == $past(enc_dc_n))
      else $error("definitions not valid with strobe");
   AST_ATOMIC_PIPE: assert property (
      cyc_start && cyc_ready && cyc_pipelined && !halt_exec && $stable(rst_b)
      |=> ##1 (suspended || atomic_n == $past(enc_atomic_n, 2)))
      else $error("pipelined locked level not one clock late");
   AST_FLOAT_HOLD: assert property (
      bus_release_ack |-> !bus_def_oe && data_bus_float)
      else $error("definitions driven during hold");
   AST_HALT_CODE: assert property (
      cyc_start && cyc_ready && cyc_kind == bus_cycle_pkg::CYC_HALT
      |=> suspended || (addr_upper == '0 && byte_lane_enables_n == 4'hb &&
          {mem_io_n, data_ctrl_n, write_read_n} == 3'h5))
      else $error("halt cycle encoding wrong");
   AST_SLEEP_IGNORED: assert property (
      s.st == bus_cycle_pkg::ST_RUN && !sleep_en |=> s.st == bus_cycle_pkg::ST_RUN)
      else $error("suspend entered while disabled");
   AST_ACK_FLOAT: assert property (
      !sleep_en |-> !sleep_ack_oe)
      else $error("acknowledge driven while disabled");
   AST_LOCK_DELAY: assert property (
      $rose(clock_doubled) |-> s.lock_cnt == bus_cycle_pkg::LOCK_CNT_MAX && pll_enable)
      else $error("doubled before lock wait");
   AST_UNDOUBLE: assert property (
      $fell(pll_enable) |-> !clock_doubled && s.lock_cnt == '0)
      else $error("doubled mode kept after clear");
   AST_SLEEP_REQUEST_N_PINS: assert property (
      suspended |-> cycle_start_strobe_n && sysmgmt_strobe_n && data_ctrl_n && atomic_n &&
         addr_upper == '1 && byte_lane_enables_n == '0 && !mem_io_n && !write_read_n &&
         !bus_release_ack && !sleep_ack_n && !core_clock_run)
      else $error("suspend pin levels wrong");
   AST_HALT_WAKE: assert property (
      s.st == bus_cycle_pkg::ST_SLEEP_HALT && |wake_now
      |=> s.st == bus_cycle_pkg::ST_RUN && wake_source != '0 ##1 wake_source == '0)
      else $error("interrupt did not end halt suspend");
   AST_DRAIN_WAIT: assert property (
      s.st == bus_cycle_pkg::ST_DRAIN_REQ && !(core_idle && pins_s[bus_cycle_pkg::PIN_BUSY_N])
      |=> s.st == bus_cycle_pkg::ST_DRAIN_REQ)
      else $error("suspend entered before drain");
   AST_LATCH_HOLD: assert property (
      s.st == bus_cycle_pkg::ST_SLEEP_REQ && irq_now[bus_cycle_pkg::IRQ_NMI]
      |=> irq_latched[bus_cycle_pkg::IRQ_NMI])
      else $error("interrupt not latched in request suspend");

   COV_REQ_SUSPEND: cover property (s.st == bus_cycle_pkg::ST_SLEEP_REQ ##1
                                    s.st == bus_cycle_pkg::ST_RUN);
   COV_HALT_WAKE: cover property (s.st == bus_cycle_pkg::ST_SLEEP_HALT ##1 wake_source != '0);
   COV_DOUBLED: cover property ($rose(clock_doubled));
   COV_PIPE_LOCK: cover property (cyc_start && cyc_pipelined && cyc_locked);
endmodule

/* rtl/bus_cycle_pkg.sv */
// shared constants and types for the bus cycle and suspend control block
package bus_cycle_pkg;
   // configuration register access through an index/data port pair
   localparam logic [15:0] INDEX_PORT      = 16'h0022;
   localparam logic [15:0] DATA_PORT       = 16'h0023;
   localparam logic [7:0]  CONFIG_INDEX    = 8'hc0;
   localparam logic [7:0]  CONFIG_RESET    = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ   = 8'hff;
   localparam int          FREQ_DOUBLE_POS = 6;
   localparam int          SLEEP_EN_POS    = 3;

   // pll lock wait
   localparam int CLK_PERIOD_PS = 5000;
   localparam int LOCK_TIME_US  = 20;
   localparam int LOCK_CYCLES   = (LOCK_TIME_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOCK_CNT_W    = 12;
   localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_MAX = LOCK_CNT_W'(LOCK_CYCLES);

   // special cycle byte enables
   localparam logic [3:0] HALT_BE_N     = 4'hb;
   localparam logic [3:0] SHUTDOWN_BE_N = 4'he;
   localparam int         ADDR_W        = 30;

   // interrupt slots for latch and wake vectors
   localparam int IRQ_NMI  = 0;
   localparam int IRQ_SYSMGMT  = 1;
   localparam int IRQ_MASKABLE = 2;

   // synchronised pin slots and their idle values
   localparam int PIN_SLEEP_N = 0;
   localparam int PIN_BUSY_N  = 1;
   localparam int PIN_NMI     = 2;
   localparam int PIN_SYSMGMT_N = 3;
   localparam int PIN_MASKABLE  = 4;
   localparam int PIN_LOCK    = 5;
   localparam int PIN_W       = 6;
   localparam logic [PIN_W-1:0] PIN_IDLE = 6'h0b;

   typedef enum logic [2:0] {
      CYC_INTA, CYC_IO_RD, CYC_IO_WR, CYC_CODE_RD,
      CYC_HALT, CYC_SHUTDOWN, CYC_MEM_RD, CYC_MEM_WR
   } cyc_kind_t;

   typedef enum logic [2:0] {
      ST_RUN, ST_DRAIN_REQ, ST_DRAIN_HALT, ST_SLEEP_REQ, ST_SLEEP_HALT
   } sleep_request_n_state_t;
endpackage

/* rtl/pin_sync.sv */
// two flip-flop synchroniser for pins arriving from outside the clock domain
module pin_sync #(
   parameter int                W       = 1,
   parameter logic [W-1:0]      RST_VAL = '0
) (
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic [W-1:0]    din,
   output logic      [W-1:0]    dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_t;

   sync_t s;
   sync_t next_s;

   if (W < 1) begin : g_bad_width
      $error("pin_sync width must be at least one");
   end

   // the first stage feeds only the second stage
   always_comb begin
      next_s.meta = din;
      next_s.q    = s.meta;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{meta: RST_VAL, q: RST_VAL};
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.q;
endmodule

/* rtl/cycle_def_encode.sv */
// decodes a bus cycle kind into the four definition levels and special enables
module cycle_def_encode (
   input  wire bus_cycle_pkg::cyc_kind_t kind,
   input  wire logic                     locked,
   output logic                          mio_n,
   output logic                          dc_n,
   output logic                          wr_n,
   output logic                          atomic_n,
   output logic                          special,
   output logic      [3:0]               special_be_n
);
   always_comb begin
      special      = 1'b0;
      special_be_n = 4'h0;
      atomic_n     = 1'b1;
      case (kind)
         bus_cycle_pkg::CYC_INTA: begin
            // acknowledge is always locked
            {mio_n, dc_n, wr_n, atomic_n} = 4'h0;
         end
         bus_cycle_pkg::CYC_IO_RD: begin
            {mio_n, dc_n, wr_n} = 3'h2;
         end
         bus_cycle_pkg::CYC_IO_WR: begin
            {mio_n, dc_n, wr_n} = 3'h3;
         end
         bus_cycle_pkg::CYC_CODE_RD: begin
            {mio_n, dc_n, wr_n} = 3'h4;
         end
         bus_cycle_pkg::CYC_HALT, bus_cycle_pkg::CYC_SHUTDOWN: begin
            {mio_n, dc_n, wr_n} = 3'h5;
            special = 1'b1;
            special_be_n = (kind == bus_cycle_pkg::CYC_HALT) ?
                           bus_cycle_pkg::HALT_BE_N : bus_cycle_pkg::SHUTDOWN_BE_N;
         end
         bus_cycle_pkg::CYC_MEM_RD: begin
            {mio_n, dc_n, wr_n} = 3'h6;
            atomic_n = !locked;
         end
         bus_cycle_pkg::CYC_MEM_WR: begin
            {mio_n, dc_n, wr_n} = 3'h7;
            atomic_n = !locked;
         end
         default: begin
            {mio_n, dc_n, wr_n} = 3'h6;
         end
      endcase
   end
endmodule

/* verif/sleep_partner.sv */
// far-side model: power controller, coprocessor and pll
module sleep_partner (
   input  wire logic clk,
   input  wire logic want_sleep,
   input  wire logic pll_enable,
   output logic      sleep_request_n,
   output logic      coproc_busy_n,
   output logic      pll_lock
);
   timeunit 1ns;
   timeprecision 1ps;
   // request is a level, dropped to resume
   always_ff @(posedge clk) sleep_request_n <= !want_sleep;
   // coprocessor idle; clock kept running, never stopped in doubled mode
   always_ff @(posedge clk) coproc_busy_n <= 1'b1;
   always_ff @(posedge clk) pll_lock <= pll_enable;
endmodule

/* verif/bus_cycle_and_suspend_control_bench.sv */
// self-checking bench for the bus cycle and suspend control block
module bus_cycle_type_and_suspend_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_b = 0, cyc_start = 0, cyc_locked = 0, cyc_pipelined = 0, cyc_smm = 0;
   logic halt_exec = 0, core_idle = 1, maskable_irq_unmasked = 1, hold_grant = 0, float_req = 0;
   logic io_wr = 0, io_rd = 0, nmi = 0, sysmgmt_irq_n = 1, maskable_irq = 0, want_sleep = 0;
   logic cyc_ready, core_clock_run, io_rvalid, pll_lock, pll_enable, clock_doubled;
   logic sleep_request_n, coproc_busy_n, cycle_start_strobe_n, sysmgmt_strobe_n, mem_io_n;
   logic data_ctrl_n, write_read_n, atomic_n, bus_def_oe, data_bus_float, bus_release_ack;
   logic sleep_ack_n, sleep_ack_oe;
   logic [2:0] irq_taken = 0, wake_source, irq_latched;
   logic [15:0] io_addr = 0;
   logic [7:0] io_wdata = 0, io_rdata;
   logic [bus_cycle_pkg::ADDR_W-1:0] cyc_addr = 30'h155, addr_upper;
   logic [3:0] cyc_be_n = 0, byte_lane_enables_n;
   bus_cycle_pkg::cyc_kind_t cyc_kind = bus_cycle_pkg::CYC_INTA;
   int errors = 0, compares = 0, i;
   // row index is the cycle kind; row holds {locked, mio dc wr atomic, byte enables}
   logic [8:0] rows [8] = '{9'h100, 9'h050, 9'h070, 9'h090, 9'h0bb, 9'h0be, 9'h1c0, 9'h0f0};
   bus_cycle_ctrl dut (.*);
   sleep_partner far (.clk(clk), .want_sleep(want_sleep), .pll_enable(pll_enable),
      .sleep_request_n(sleep_request_n), .coproc_busy_n(coproc_busy_n), .pll_lock(pll_lock));
   always #2.5 clk = !clk;
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task io(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      {io_wr, io_rd, io_addr, io_wdata} = {wr, !wr, a, d};
      @(negedge clk);
      {io_wr, io_rd} = 2'h0;
   endtask
   task cyc(input int k, input logic lk);
      @(negedge clk);
      {cyc_start, cyc_kind, cyc_locked} = {1'b1, bus_cycle_pkg::cyc_kind_t'(k[2:0]), lk};
      @(negedge clk);
      cyc_start = 0;
   endtask
   task final_report;
      if (errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #60000;
      errors++;
      final_report;
   end
   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1;
      chk({sleep_ack_oe, clock_doubled, cycle_start_strobe_n, core_clock_run}, 4'h3);
      for (i = 0; i < 8; i++) begin
         cyc(i, rows[i][8]);
         chk({cycle_start_strobe_n, mem_io_n, data_ctrl_n, write_read_n, atomic_n}, rows[i][7:4]);
         chk({byte_lane_enables_n, addr_upper}, {rows[i][3:0], (i == 4 || i == 5) ? 30'h0 : cyc_addr});
      end
      cyc_pipelined = 1;
      cyc(6, 1);
      chk({cycle_start_strobe_n, atomic_n}, 2'h1);
      @(negedge clk);
      chk({cycle_start_strobe_n, atomic_n}, 2'h2);
      hold_grant = 1;
      repeat (2) @(negedge clk);
      chk({bus_def_oe, data_bus_float, bus_release_ack}, 3'h3);
      {hold_grant, want_sleep} = 2'h1;
      repeat (10) @(negedge clk);
      chk(sleep_ack_n, 1);
      want_sleep = 0;
      repeat (6) @(negedge clk);
      io(1, 16'h0022, 8'hc0);
      io(1, 16'h0023, 8'h48);
      chk({pll_enable, sleep_ack_oe}, 2'h3);
      io(1, 16'h0022, 8'hc0);
      io(0, 16'h0023, 0);
      chk(io_rvalid, 1);
      @(negedge clk);
      chk(io_rdata, 8'h48);
      io(0, 16'h0023, 0);
      @(negedge clk);
      chk(io_rdata, 8'hff);
      repeat (3880) @(negedge clk);
      chk(clock_doubled, 0);
      repeat (200) @(negedge clk);
      chk(clock_doubled, 1);
      want_sleep = 1;
      for (i = 0; i < 40 && sleep_ack_n !== 1'b0; i++) @(negedge clk);
      chk({sleep_ack_n, core_clock_run, cyc_ready, cycle_start_strobe_n, mem_io_n, addr_upper[0],
         byte_lane_enables_n, clock_doubled}, 10'h0a1);
      nmi = 1;
      repeat (4) @(negedge clk);
      nmi = 0;
      chk(irq_latched[0], 1);
      want_sleep = 0;
      for (i = 0; i < 40 && sleep_ack_n !== 1'b1; i++) @(negedge clk);
      chk(sleep_ack_n, 1);
      io(1, 16'h0022, 8'hc0);
      io(1, 16'h0023, 8'h08);
      @(negedge clk);
      chk(clock_doubled, 0);
      halt_exec = 1;
      @(negedge clk);
      halt_exec = 0;
      for (i = 0; i < 40 && sleep_ack_n !== 1'b0; i++) @(negedge clk);
      chk(sleep_ack_n, 0);
      maskable_irq = 1;
      for (i = 0; i < 40 && wake_source === 3'h0; i++) @(negedge clk);
      chk(wake_source, 3'h4);
      final_report;
   end
endmodule
